// ---- design/two_wire_config_slave.sv ----
// Two-wire configuration slave with its register set
`timescale 1ns/1ps
`default_nettype none
module two_wire_config_slave #(
    parameter logic [3:0] DEVICE_ID = twcs_pkg::DEVICE_ID_RESET
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [4:0] factoryBandCode,
    input wire logic nvmWriteBusy,
    output logic nvmWriteStart,
    output var twcs_pkg::twcs_config_type cfgOut
);

    twcs_pkg::twcs_bus_event_type ev;
    twcs_pkg::twcs_state_type state;
    logic [3:0] bitCount;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic [7:0] pointer;
    logic havePointer;
    logic masterAck;
    logic [7:0] dividerReg;
    logic [7:0] stepHighReg;
    logic [7:0] stepLowReg;
    logic [7:0] bandReg;
    logic [7:0] busIdReg;
    logic addrHit;
    logic rxByteEnd;
    logic wrFire;
    logic txByteEnd;
    logic [7:0] txNext;

    twcs_pin_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .events(ev)
    );

    // Readback of the register at a pointer
    function automatic logic [7:0] readReg(input logic [7:0] ptr);
        logic [7:0] value;
        value = 8'h00;
        unique case (ptr)
            twcs_pkg::REG_DIVIDER: value = dividerReg;
            twcs_pkg::REG_STEP_HIGH: value = stepHighReg;
            twcs_pkg::REG_STEP_LOW: value = stepLowReg;
            twcs_pkg::REG_BAND: value = bandReg;
            twcs_pkg::REG_BUS_ID: value = busIdReg;
            twcs_pkg::REG_FACTORY_BAND: value = {3'h0, factoryBandCode};
            default: value = 8'h00;
        endcase
        return value;
    endfunction

    // Exponent saturation at eight
    function automatic logic [3:0] satExp(input logic [3:0] raw);
        return (raw > twcs_pkg::DIV_EXP_MAX) ? twcs_pkg::DIV_EXP_MAX : raw;
    endfunction

    // All eight bits of a byte clocked
    function automatic logic byteDone(input logic [3:0] count);
        return count == twcs_pkg::BITS_PER_BYTE;
    endfunction

    // Open-drain pull needed for the leading bit
    function automatic logic drivesLow(input logic [7:0] data);
        return !data[7];
    endfunction

    // Register pointer auto-increment, wraps at the top
    function automatic logic [7:0] nextPtr(input logic [7:0] ptr);
        return ptr + 8'h01;
    endfunction

    // Identifier, bus address bits, then direction
    function automatic logic addrMatch(input logic [7:0] rxByte, input logic [7:0] busId);
        return rxByte[7:1] == {DEVICE_ID, busId[2:0]};
    endfunction

    // Bus identity always commits; others only without the policy
    function automatic logic commitWanted(input logic [7:0] ptr, input logic policy);
        return (ptr == twcs_pkg::REG_BUS_ID) || (!policy && ptr < twcs_pkg::REG_FACTORY_BAND);
    endfunction

    always_comb
    begin
        addrHit = addrMatch(rxShift, busIdReg) && !nvmWriteBusy;
        rxByteEnd = ev.sclFall && byteDone(bitCount);
        wrFire = rxByteEnd && (state == twcs_pkg::ST_RX) && !nvmWriteBusy;
        txByteEnd = ev.sclFall && byteDone(bitCount) && (state == twcs_pkg::ST_TX);
        txNext = readReg(pointer);
    end

    // Bus protocol sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= twcs_pkg::ST_IDLE;
            bitCount <= 4'h0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            sdaOe <= 1'b0;
            masterAck <= 1'b0;
        end
        else if (ev.start)
        begin
            // Repeated START restarts addressing at once
            state <= twcs_pkg::ST_ADDR;
            bitCount <= 4'h0;
            sdaOe <= 1'b0;
        end
        else if (ev.stop)
        begin
            state <= twcs_pkg::ST_IDLE;
            bitCount <= 4'h0;
            sdaOe <= 1'b0;
        end
        else
        begin
            unique case (state)
                twcs_pkg::ST_IDLE,
                twcs_pkg::ST_IGNORE:
                begin
                    sdaOe <= 1'b0;
                end
                twcs_pkg::ST_ADDR,
                twcs_pkg::ST_RX:
                begin
                    if (ev.sclRise && !byteDone(bitCount))
                    begin
                        rxShift <= {rxShift[6:0], ev.sda};
                        bitCount <= bitCount + 4'h1;
                    end
                    else if (rxByteEnd)
                    begin
                        bitCount <= 4'h0;
                        if (state == twcs_pkg::ST_ADDR)
                        begin
                            // Pull low before the ninth clock rises
                            sdaOe <= addrHit;
                            state <= addrHit ? twcs_pkg::ST_ADDR_ACK : twcs_pkg::ST_IGNORE;
                        end
                        else
                        begin
                            sdaOe <= !nvmWriteBusy;
                            state <= nvmWriteBusy ? twcs_pkg::ST_IGNORE : twcs_pkg::ST_RX_ACK;
                        end
                    end
                end
                twcs_pkg::ST_ADDR_ACK:
                begin
                    if (ev.sclFall)
                    begin
                        if (rxShift[0])
                        begin
                            // First data bit goes out on this fall
                            state <= twcs_pkg::ST_TX;
                            txShift <= txNext;
                            sdaOe <= drivesLow(txNext);
                        end
                        else
                        begin
                            state <= twcs_pkg::ST_RX;
                            sdaOe <= 1'b0;
                        end
                        bitCount <= 4'h0;
                    end
                end
                twcs_pkg::ST_RX_ACK:
                begin
                    if (ev.sclFall)
                    begin
                        sdaOe <= 1'b0;
                        state <= twcs_pkg::ST_RX;
                    end
                end
                twcs_pkg::ST_TX:
                begin
                    if (ev.sclRise)
                    begin
                        bitCount <= bitCount + 4'h1;
                    end
                    else if (txByteEnd)
                    begin
                        // Release for the master's acknowledge
                        sdaOe <= 1'b0;
                        bitCount <= 4'h0;
                        masterAck <= 1'b0;
                        state <= twcs_pkg::ST_TX_ACK;
                    end
                    else if (ev.sclFall)
                    begin
                        sdaOe <= drivesLow({txShift[6:0], 1'b0});
                        txShift <= {txShift[6:0], 1'b0};
                    end
                end
                twcs_pkg::ST_TX_ACK:
                begin
                    if (ev.sclRise)
                    begin
                        masterAck <= !ev.sda;
                    end
                    else if (ev.sclFall)
                    begin
                        if (masterAck)
                        begin
                            state <= twcs_pkg::ST_TX;
                            txShift <= txNext;
                            sdaOe <= drivesLow(txNext);
                        end
                        else
                        begin
                            // Last byte: leave SDA high for STOP
                            state <= twcs_pkg::ST_IGNORE;
                            sdaOe <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Register pointer: first written byte, then auto-increment
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pointer <= 8'h00;
            havePointer <= 1'b0;
        end
        else if (ev.start)
        begin
            havePointer <= 1'b0;
        end
        else if (wrFire)
        begin
            if (!havePointer)
            begin
                pointer <= rxShift;
                havePointer <= 1'b1;
            end
            else
            begin
                pointer <= nextPtr(pointer);
            end
        end
        else if (txByteEnd)
        begin
            pointer <= nextPtr(pointer);
        end
    end

    // Configuration register writes
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dividerReg <= twcs_pkg::DIVIDER_RESET;
            stepHighReg <= twcs_pkg::STEP_HIGH_RESET;
            stepLowReg <= twcs_pkg::STEP_LOW_RESET;
            bandReg <= twcs_pkg::BAND_RESET;
            busIdReg <= twcs_pkg::BUS_ID_RESET;
        end
        else if (wrFire && havePointer)
        begin
            unique case (pointer)
                twcs_pkg::REG_DIVIDER: dividerReg <= rxShift;
                twcs_pkg::REG_STEP_HIGH: stepHighReg <= rxShift;
                twcs_pkg::REG_STEP_LOW: stepLowReg <= rxShift;
                twcs_pkg::REG_BAND: bandReg <= rxShift;
                twcs_pkg::REG_BUS_ID: busIdReg <= rxShift;
                default: ;
            endcase
        end
    end

    // Nonvolatile commit request
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nvmWriteStart <= 1'b0;
        end
        else if (wrFire && !havePointer)
        begin
            nvmWriteStart <= (rxShift == twcs_pkg::CMD_COMMIT);
        end
        else if (wrFire)
        begin
            nvmWriteStart <= commitWanted(pointer, busIdReg[twcs_pkg::POLICY_BIT]);
        end
        else
        begin
            nvmWriteStart <= 1'b0;
        end
    end

    // Decoded configuration outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfgOut <= '0;
        end
        else
        begin
            cfgOut.divideExponent <= satExp(dividerReg[3:0]);
            cfgOut.ditherDepthSelect <= dividerReg[twcs_pkg::DITHER_BIT];
            cfgOut.bandSelect <= bandReg[4:0];
            cfgOut.fineStep <= {stepHighReg, stepLowReg[7:6]};
            cfgOut.busAddress <= busIdReg[2:0];
            cfgOut.commitPolicyBit <= busIdReg[twcs_pkg::POLICY_BIT];
        end
    end

    // Open-drain drivers: low when enabled, never drive SCL
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
        end
        else
        begin
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- design/twcs_pkg.sv ----
// Constants and types of the two-wire configuration slave
package twcs_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int SCL_STD_HZ = 100_000;
    localparam int SCL_FAST_HZ = 400_000;
    localparam int SCL_HALF_CYCLES = CLK_HZ / (2 * SCL_FAST_HZ);
    localparam int FINE_STEP_HZ = 10_000;

    localparam logic [3:0] DEVICE_ID_RESET = 4'hb;

    localparam logic [7:0] REG_DIVIDER = 8'h00;
    localparam logic [7:0] REG_STEP_HIGH = 8'h01;
    localparam logic [7:0] REG_STEP_LOW = 8'h02;
    localparam logic [7:0] REG_BAND = 8'h03;
    localparam logic [7:0] REG_BUS_ID = 8'h04;
    localparam logic [7:0] REG_FACTORY_BAND = 8'h05;
    localparam logic [7:0] CMD_COMMIT = 8'h06;

    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [7:0] STEP_HIGH_RESET = 8'h00;
    localparam logic [7:0] STEP_LOW_RESET = 8'h00;
    localparam logic [7:0] BAND_RESET = 8'h00;
    localparam logic [7:0] BUS_ID_RESET = 8'h00;

    localparam int DIV_EXP_LSB = 0;
    localparam int DIV_EXP_W = 4;
    localparam int DITHER_BIT = 4;
    localparam logic [3:0] DIV_EXP_MAX = 4'h8;
    localparam int STEP_W = 10;
    localparam int BAND_W = 5;
    localparam int BUS_ADDR_W = 3;
    localparam int POLICY_BIT = 3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic [DIV_EXP_W-1:0] divideExponent;
        logic ditherDepthSelect;
        logic [BAND_W-1:0] bandSelect;
        logic [STEP_W-1:0] fineStep;
        logic [BUS_ADDR_W-1:0] busAddress;
        logic commitPolicyBit;
    } twcs_config_type;

    typedef struct packed {
        logic sclRise;
        logic sclFall;
        logic start;
        logic stop;
        logic sda;
    } twcs_bus_event_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } twcs_state_type;

endpackage

// ---- design/twcs_pin_sync.sv ----
// Pin synchroniser and bus condition detector
`timescale 1ns/1ps
`default_nettype none
module twcs_pin_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output var twcs_pkg::twcs_bus_event_type events
);

    logic [2:0] sclPipe;
    logic [2:0] sdaPipe;

    // Stage 0 feeds only stage 1; edges use stages 1 and 2
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclPipe <= 3'h7;
            sdaPipe <= 3'h7;
        end
        else
        begin
            sclPipe <= {sclPipe[1:0], sclIn};
            sdaPipe <= {sdaPipe[1:0], sdaIn};
        end
    end

    // Two-cycle latency stays well inside a fast-mode half period
    always_comb
    begin
        events.sclRise = sclPipe[1] && !sclPipe[2];
        events.sclFall = !sclPipe[1] && sclPipe[2];
        events.start = sclPipe[1] && sclPipe[2] && sdaPipe[2] && !sdaPipe[1];
        events.stop = sclPipe[1] && sclPipe[2] && !sdaPipe[2] && sdaPipe[1];
        events.sda = sdaPipe[1];
    end

endmodule
`default_nettype wire

// ---- verif/twcs_sva.sv ----
// Port assertions for the two-wire configuration slave
`timescale 1ns/1ps
`default_nettype none
module twcs_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [4:0] factoryBandCode,
    input wire logic nvmWriteBusy,
    input wire logic nvmWriteStart,
    input wire twcs_pkg::twcs_config_type cfgOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_SCL_FREE: assert property (!sclOe && !sclOut)
        else $error("slave drove SCL");
    AST_SDA_DRAIN: assert property (sdaOe |-> !sdaOut)
        else $error("SDA driven high");
    AST_SDA_STEADY: assert property (sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe))
        else $error("SDA moved while SCL high");
    AST_ACK_HOLD: assert property ($rose(sdaOe) |=> sdaOe [*6])
        else $error("SDA low not held");
    AST_BUSY_NACK: assert property (nvmWriteBusy && $past(nvmWriteBusy, 8) |-> !$rose(sdaOe))
        else $error("answered while busy");
    AST_BUSY_NOCOMMIT: assert property (nvmWriteBusy |-> !nvmWriteStart)
        else $error("commit while busy");
    AST_COMMIT_PULSE: assert property (nvmWriteStart |=> !nvmWriteStart)
        else $error("commit pulse too long");
    AST_CFG_TIMING: assert property (!$stable(cfgOut) |-> !$past(sclIn, 2) && !$past(nvmWriteBusy))
        else $error("config changed off byte end");
    AST_EXP_SAT: assert property (cfgOut.divideExponent <= twcs_pkg::DIV_EXP_MAX)
        else $error("exponent above limit");
endmodule
`default_nettype wire

// ---- verif/twcs_bus_master.sv ----
// Behavioural two-wire bus master, SCL half period of four clocks
`timescale 1ns/1ps
`default_nettype none
module twcs_bus_master (
    input wire logic clk,
    input wire logic sdaIn,
    output logic sclM,
    output logic sdaM
);
    initial
    begin
        sclM = 1'b1;
        sdaM = 1'b1;
    end
    task automatic hp();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Also serves as repeated START
    task automatic start();
        sdaM = 1'b1;
        hp();
        sclM = 1'b1;
        hp();
        sdaM = 1'b0;
        hp();
        sclM = 1'b0;
    endtask
    task automatic stop();
        sdaM = 1'b0;
        hp();
        sclM = 1'b1;
        hp();
        sdaM = 1'b1;
        hp();
    endtask
    // Level held through the high phase
    task automatic bitX(input logic b, output logic r);
        sdaM = b;
        hp();
        sclM = 1'b1;
        hp();
        r = sdaIn;
        sclM = 1'b0;
    endtask
    task automatic byteX(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitX(d[i], q[i]);
        bitX(a, ack);
    endtask
endmodule
`default_nettype wire

// ---- verif/two_wire_config_slave_tb.sv ----
// Self-checking bench for the two-wire configuration slave
`timescale 1ns/1ps
`default_nettype none
module two_wire_config_slave_tb;
    typedef struct packed {logic [7:0] ptr; logic [7:0] data; logic rb;} twcs_row_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic nvmWriteBusy = 1'b0;
    logic [4:0] factoryBandCode = 5'h12;
    logic sclM, sdaM, sclOut, sclOe, sdaOut, sdaOe, nvmWriteStart, ack;
    logic [7:0] q;
    logic [7:0] sh [8] = '{default: 8'h00};
    twcs_pkg::twcs_config_type cfgOut;
    int numErrors = 0;
    int nChecks = 0;
    int commits = 0;
    wire logic sclW = sclM & ~sclOe;
    wire logic sdaW = sdaM & ~sdaOe;
    twcs_row_type rows [8] = '{'{twcs_pkg::REG_DIVIDER, 8'h10, 1'b1}, '{twcs_pkg::REG_DIVIDER, 8'h0c, 1'b0},
        '{twcs_pkg::REG_DIVIDER, 8'h00, 1'b1}, '{twcs_pkg::REG_STEP_HIGH, 8'hff, 1'b1},
        '{twcs_pkg::REG_STEP_LOW, 8'hc0, 1'b1}, '{twcs_pkg::REG_STEP_HIGH, 8'h44, 1'b1},
        '{twcs_pkg::REG_STEP_LOW, 8'h00, 1'b1}, '{twcs_pkg::REG_BAND, 8'h13, 1'b1}};

    always #50 clk = ~clk;
    always @(posedge clk)
        if (nvmWriteStart === 1'b1)
            commits <= commits + 1;

    two_wire_config_slave dut_u (.clk(clk), .reset_n(reset_n), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .factoryBandCode(factoryBandCode),
        .nvmWriteBusy(nvmWriteBusy), .nvmWriteStart(nvmWriteStart), .cfgOut(cfgOut));
    twcs_bus_master master_u (.clk(clk), .sdaIn(sdaW), .sclM(sclM), .sdaM(sdaM));

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        nChecks++;
        if (g !== e)
        begin
            $display("BAD %0t %h %h", $time, g, e);
            numErrors++;
        end
    endtask
    task automatic results();
        if (numErrors == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [23:0] expCfg();
        return {(sh[0][3:0] > 4'h8) ? 4'h8 : sh[0][3:0], sh[0][4], sh[3][4:0], sh[1], sh[2][7:6], sh[4][2:0], sh[4][3]};
    endfunction
    function automatic logic [7:0] addr(input logic rw);
        return {twcs_pkg::DEVICE_ID_RESET, sh[4][2:0], rw};
    endfunction
    task automatic hdr(input logic [7:0] p);
        master_u.start();
        master_u.byteX(addr(1'b0), 1'b1, q, ack);
        master_u.byteX(p, 1'b1, q, ack);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic nak);
        master_u.start();
        master_u.byteX(addr(1'b0), 1'b1, q, ack);
        chk({23'h0, ack}, {23'h0, nak});
        if (nak == 1'b0)
        begin
            master_u.byteX(p, 1'b1, q, ack);
            master_u.byteX(d, 1'b1, q, ack);
            chk({23'h0, ack}, 24'h0);
            if (p < 8'h05)
                sh[p[2:0]] = d;
        end
        master_u.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic last);
        hdr(p);
        master_u.start();
        master_u.byteX(addr(1'b1), 1'b1, q, ack);
        chk({23'h0, ack}, 24'h0);
        master_u.byteX(8'hff, last, q, ack);
        if (last)
            master_u.stop();
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        numErrors++;
        results();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(cfgOut, 24'h0);
        rd(twcs_pkg::REG_FACTORY_BAND, 1'b1);
        chk({16'h0, q}, {19'h0, factoryBandCode});
        for (int i = 0; i < 8; i++)
        begin
            wr(rows[i].ptr, rows[i].data, 1'b0);
            chk(cfgOut, expCfg());
            if (rows[i].rb)
            begin
                rd(rows[i].ptr, 1'b1);
                chk({16'h0, q}, {16'h0, rows[i].data});
            end
        end
        chk(24'(commits), 24'h8);
        wr(twcs_pkg::REG_STEP_HIGH, 8'h5a, 1'b0);
        rd(twcs_pkg::REG_STEP_HIGH, 1'b0);
        chk({16'h0, q}, 24'h5a);
        master_u.byteX(8'hff, 1'b1, q, ack);
        master_u.stop();
        chk({16'h0, q}, {16'h0, sh[2]});
        wr(twcs_pkg::REG_BUS_ID, 8'h0d, 1'b0);
        wr(twcs_pkg::REG_DIVIDER, 8'h03, 1'b0);
        chk(cfgOut, expCfg());
        chk(24'(commits), 24'ha);
        hdr(twcs_pkg::CMD_COMMIT);
        master_u.stop();
        chk(24'(commits), 24'hb);
        master_u.start();
        master_u.byteX({twcs_pkg::DEVICE_ID_RESET, 3'h2, 1'b0}, 1'b1, q, ack);
        master_u.stop();
        chk({23'h0, ack}, 24'h1);
        nvmWriteBusy = 1'b1;
        wr(twcs_pkg::REG_BAND, 8'h05, 1'b1);
        nvmWriteBusy = 1'b0;
        chk(cfgOut, expCfg());
        hdr(twcs_pkg::REG_BAND);
        nvmWriteBusy = 1'b1;
        master_u.byteX(8'h07, 1'b1, q, ack);
        master_u.stop();
        nvmWriteBusy = 1'b0;
        chk({23'h0, ack}, 24'h1);
        chk(cfgOut, expCfg());
        hdr(twcs_pkg::REG_BAND);
        for (int i = 0; i < 4; i++)
            master_u.bitX(1'b1, ack);
        master_u.stop();
        chk(cfgOut, expCfg());
        wr(twcs_pkg::REG_BAND, 8'h05, 1'b0);
        chk(cfgOut, expCfg());
        reset_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        @(posedge clk);
        #1 chk(cfgOut, 24'h0);
        results();
    end
endmodule

bind two_wire_config_slave twcs_sva chk_u (.clk(clk), .reset_n(reset_n), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .factoryBandCode(factoryBandCode),
    .nvmWriteBusy(nvmWriteBusy), .nvmWriteStart(nvmWriteStart), .cfgOut(cfgOut));
`default_nettype wire
